/* src/ipe_event_regs.v */
// How it works
// - per receive event, publish word with channel index and enable bit
// - combined interrupt enable register, directly readable and writable
// - writing one to set register enables that interrupt; reads show enables
// - writing one to clear register disables that interrupt; reads show enables
// - read-only pending register, flag and enable, resets to zero
// - per receive event, eight-bit channel mask selecting channels that raise it
// - eight send configuration words choosing channels each send task drives
// - four general purpose scratch words, kept only while powered
// - send task n pulses every channel enabled in its send word
// - receive flag n sets on event from any masked channel
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "ipe_map.vh"
module ipe_event_regs #(
  parameter NEV = 8,
  parameter NCH = 8
) (
  // clock and reset
  input  wire          sys_clk,
  input  wire          nrst,
  input  wire          clkEn,
  // register port
  input  wire [11:0]   regAddr,
  input  wire [31:0]   regWrData,
  input  wire          regWrEn,
  input  wire          regRdEn,
  output reg  [31:0]   regRdData,
  // shared channel lines, from other units (asynchronous)
  input  wire [NCH-1:0] chanIn,
  // channel pulses driven by this unit
  output reg  [NCH-1:0] chanOut,
  // published events: one pulse per event plus its channel index
  output reg  [NEV-1:0] pubValid,
  output reg  [NEV*16-1:0] pubIndex,
  // interrupt
  output wire          irq
);
  // ****************************************
  // address decode
  // ****************************************
  wire [2:0] slot     = regAddr[4:2];
  wire inSend  = (regAddr[11:5] == `IPE_SEND_TRIG_BASE >> 5);
  wire inRecv  = (regAddr[11:5] == `IPE_RECV_EVENT_BASE >> 5);
  wire inPub   = (regAddr[11:5] == `IPE_PUB_CFG_BASE >> 5);
  // send and receive cfg arrays start at 0x10 offset within a 32-byte aligned block
  wire [11:0] sendRel = regAddr - `IPE_SEND_CFG_BASE;
  wire [11:0] maskRel = regAddr - `IPE_RECV_MASK_BASE;
  wire [11:0] scrRel  = regAddr - `IPE_SCRATCH_BASE;
  wire inSendCfg = (sendRel[11:5] == 7'h00) && (sendRel[1:0] == 2'b00);
  wire inMask    = (maskRel[11:5] == 7'h00) && (maskRel[1:0] == 2'b00);
  wire inScr     = (scrRel[11:4] == 8'h00) && (scrRel[1:0] == 2'b00);
  wire isEn  = (regAddr == `IPE_INT_ENABLE);
  wire isSet = (regAddr == `IPE_INT_ENABLE_SET);
  wire isClr = (regAddr == `IPE_INT_ENABLE_CLEAR);
  wire isPnd = (regAddr == `IPE_INT_PENDING);
  wire wr = regWrEn && clkEn;

  // ****************************************
  // configuration words
  // ****************************************
  wire [31:0] pubWord  [0:NEV-1];
  wire [31:0] sendWord [0:NEV-1];
  wire [31:0] maskWord [0:NEV-1];
  genvar g;
  generate
    for (g = 0; g < NEV; g = g + 1) begin : gCfg
      // publish index and enable live in one word
      ipe_word_reg #(.WIDTH(32), .RESET_VALUE(`IPE_CFG_RESET)) uPub (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .clkEn   (clkEn),
        .wrEn    (wr && inPub && slot == g),
        .wrData  (regWrData & 32'h8000FFFF),
        .value_r (pubWord[g])
      );
      // channels this send task drives
      ipe_word_reg #(.WIDTH(32), .RESET_VALUE(`IPE_CFG_RESET)) uSend (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .clkEn   (clkEn),
        .wrEn    (wr && inSendCfg && sendRel[4:2] == g),
        .wrData  ({24'h000000, regWrData[7:0]}),
        .value_r (sendWord[g])
      );
      // channels this receive event listens to
      ipe_word_reg #(.WIDTH(32), .RESET_VALUE(`IPE_CFG_RESET)) uMask (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .clkEn   (clkEn),
        .wrEn    (wr && inMask && maskRel[4:2] == g),
        .wrData  ({24'h000000, regWrData[7:0]}),
        .value_r (maskWord[g])
      );
    end
  endgenerate

  // ****************************************
  // scratch storage
  // ****************************************
  wire [31:0] scrData;
  ipe_scratch_mem #(.DEPTH(`IPE_SCRATCH_COUNT), .AWIDTH(2), .WIDTH(32)) uScr (
    .sys_clk  (sys_clk),
    .clkEn    (clkEn),
    .wrEn     (wr && inScr),
    .wrAddr   (scrRel[3:2]),
    .wrData   (regWrData),
    .rdAddr   (scrRel[3:2]),
    .rdData_r (scrData)
  );

  // ****************************************
  // channel input synchroniser
  // ****************************************
  reg [NCH-1:0] chS1_r, chS2_r, chS3_r, chPrev_r;
  // a change only counts once the second and third stages agree
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      chS1_r   <= {NCH{1'b0}};
      chS2_r   <= {NCH{1'b0}};
      chS3_r   <= {NCH{1'b0}};
      chPrev_r <= {NCH{1'b0}};
    end else if (clkEn) begin
      chS1_r <= chanIn;
      chS2_r <= chS1_r;
      chS3_r <= chS2_r;
      chPrev_r <= (chS2_r & chS3_r) | (chPrev_r & (chS2_r | chS3_r));
    end
  end
  wire [NCH-1:0] chStable = (chS2_r & chS3_r) | (chPrev_r & (chS2_r | chS3_r));
  // rising edge of a filtered line is one channel event; close events merge
  wire [NCH-1:0] chEvent = chStable & ~chPrev_r;

  // ****************************************
  // send tasks
  // ****************************************
  reg [NCH-1:0] sendHit;
  integer k;
  // writing one to trigger word n fires the channels of send word n
  always @* begin
    sendHit = {NCH{1'b0}};
    for (k = 0; k < NEV; k = k + 1) begin
      if (wr && inSend && slot == k && regWrData[0]) begin
        sendHit = sendHit | sendWord[k][NCH-1:0];
      end
    end
  end
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      chanOut <= {NCH{1'b0}};
    end else if (clkEn) begin
      chanOut <= sendHit; // one-cycle pulse per trigger
    end
  end

  // ****************************************
  // receive flags, interrupt enables
  // ****************************************
  reg  [NEV-1:0] flag_r, flag_nxt, interrupt_enable_r, interrupt_enable_nxt;
  reg  [NEV-1:0] hit;
  integer e;
  always @* begin
    hit = {NEV{1'b0}};
    for (e = 0; e < NEV; e = e + 1) begin
      hit[e] = |(chEvent & maskWord[e][NCH-1:0]);
    end
    flag_nxt = flag_r;
    // software writes the flag word; hardware set wins over a clear
    if (wr && inRecv) begin
      flag_nxt[slot] = regWrData[0];
    end
    flag_nxt = flag_nxt | hit;
    interrupt_enable_nxt = interrupt_enable_r;
    if (wr && isEn) begin
      interrupt_enable_nxt = regWrData[NEV-1:0];
    end
    if (wr && isSet) begin
      interrupt_enable_nxt = interrupt_enable_r | regWrData[NEV-1:0];
    end
    if (wr && isClr) begin
      interrupt_enable_nxt = interrupt_enable_r & ~regWrData[NEV-1:0];
    end
  end
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      flag_r  <= {NEV{1'b0}};
      interrupt_enable_r <= {NEV{1'b0}};
    end else if (clkEn) begin
      flag_r  <= flag_nxt;
      interrupt_enable_r <= interrupt_enable_nxt;
    end
  end
  wire [NEV-1:0] pending = flag_r & interrupt_enable_r;
  assign irq = |pending;

  // ****************************************
  // publishing of receive events
  // ****************************************
  integer p;
  // only enabled publish words forward their event
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pubValid <= {NEV{1'b0}};
      pubIndex <= {NEV*16{1'b0}};
    end else if (clkEn) begin
      for (p = 0; p < NEV; p = p + 1) begin
        pubValid[p] <= hit[p] & pubWord[p][`IPE_PUB_EN_BIT];
        pubIndex[p*16 +: 16] <= pubWord[p][`IPE_PUB_IDX_MSB:0];
      end
    end
  end

  // ****************************************
  // read back
  // ****************************************
  reg [31:0] rdMux;
  reg        rdScr_r;
  always @* begin
    rdMux = 32'h00000000;
    if (inPub) begin
      rdMux = pubWord[slot];
    end else if (inRecv) begin
      rdMux = {31'h00000000, flag_r[slot]};
    end else if (isEn || isSet || isClr) begin
      rdMux = {24'h000000, interrupt_enable_r};
    end else if (isPnd) begin
      rdMux = {24'h000000, pending};
    end else if (inSendCfg) begin
      rdMux = sendWord[sendRel[4:2]];
    end else if (inMask) begin
      rdMux = maskWord[maskRel[4:2]];
    end
  end
  reg [31:0] rdHold_r;
  // data stands only in the cycle after the read strobe
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rdHold_r <= 32'h00000000;
      rdScr_r  <= 1'b0;
    end else if (clkEn) begin
      rdHold_r <= regRdEn ? rdMux : 32'h00000000;
      rdScr_r  <= regRdEn && inScr;
    end
  end
  always @* begin
    regRdData = rdScr_r ? scrData : rdHold_r;
  end
endmodule
`default_nettype wire

/* src/ipe_map.vh */
`ifndef IPE_MAP_VH
`define IPE_MAP_VH
// ****************************************
// register offsets (byte addresses)
// ****************************************
`define IPE_SEND_TRIG_BASE    12'h000
`define IPE_RECV_EVENT_BASE   12'h100
`define IPE_PUB_CFG_BASE      12'h180
`define IPE_INT_ENABLE        12'h300
`define IPE_INT_ENABLE_SET    12'h304
`define IPE_INT_ENABLE_CLEAR  12'h308
`define IPE_INT_PENDING       12'h30C
`define IPE_SEND_CFG_BASE     12'h510
`define IPE_RECV_MASK_BASE    12'h590
`define IPE_SCRATCH_BASE      12'h610
// ****************************************
// field positions and reset values
// ****************************************
`define IPE_PUB_EN_BIT        31
`define IPE_PUB_IDX_MSB       15
`define IPE_CFG_RESET         32'h00000000
`define IPE_EVENT_COUNT       8
`define IPE_CHANNEL_COUNT     8
`define IPE_SCRATCH_COUNT     4
// ****************************************
// timing
// ****************************************
`define IPE_MERGE_WINDOW_US   165
`define IPE_CLK_MHZ           200
`define IPE_MERGE_WINDOW_CYC  (`IPE_MERGE_WINDOW_US * `IPE_CLK_MHZ)
`endif

/* src/ipe_word_reg.v */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// one software-writable word with reset value
// ****************************************
module ipe_word_reg #(
  parameter WIDTH = 32,
  parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
  // clock and reset
  input  wire             sys_clk,
  input  wire             nrst,
  input  wire             clkEn,
  // write side
  input  wire             wrEn,
  input  wire [WIDTH-1:0] wrData,
  // stored value
  output reg  [WIDTH-1:0] value_r
);
  // plain loadable word, frozen while the clock enable is low
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      value_r <= RESET_VALUE;
    end else if (clkEn && wrEn) begin
      value_r <= wrData;
    end
  end
endmodule
`default_nettype wire

/* src/ipe_scratch_mem.v */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// small scratch storage with registered read
// ****************************************
module ipe_scratch_mem #(
  parameter DEPTH  = 4,
  parameter AWIDTH = 2,
  parameter WIDTH  = 32
) (
  // clock
  input  wire              sys_clk,
  input  wire              clkEn,
  // write port
  input  wire              wrEn,
  input  wire [AWIDTH-1:0] wrAddr,
  input  wire [WIDTH-1:0]  wrData,
  // read port
  input  wire [AWIDTH-1:0] rdAddr,
  output reg  [WIDTH-1:0]  rdData_r
);
  reg [WIDTH-1:0] memWords [0:DEPTH-1];
  // no reset: contents are only kept while powered, like ordinary ram
  always @(posedge sys_clk) begin
    if (clkEn) begin
      if (wrEn) begin
        memWords[wrAddr] <= wrData;
      end
      rdData_r <= memWords[rdAddr];
    end
  end
endmodule
`default_nettype wire

/* tb/ipe_event_regs_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// port checker for the event registers
// ****
module ipe_event_regs_asserts #(parameter NEV = 8, parameter NCH = 8) (
  // clock and register port
  input wire logic              sys_clk,
  input wire logic              nrst,
  input wire logic              clkEn,
  input wire logic [11:0]       regAddr,
  input wire logic [31:0]       regWrData,
  input wire logic              regWrEn,
  input wire logic              regRdEn,
  input wire logic [31:0]       regRdData,
  // channels, publish and interrupt
  input wire logic [NCH-1:0]    chanIn,
  input wire logic [NCH-1:0]    chanOut,
  input wire logic [NEV-1:0]    pubValid,
  input wire logic [NEV*16-1:0] pubIndex,
  input wire logic              irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // strobes that the block really takes
  wire logic rdTk = regRdEn && clkEn;
  wire logic wrTk = regWrEn && clkEn;
  chk_read_slot: assert property (regRdData != 0 |-> $past(rdTk))
    else $error("read data outside its slot");
  chk_unmapped_zero: assert property (rdTk && regAddr == 12'hFFC |=> regRdData == 0)
    else $error("unmapped read not zero");
  chk_set_view: assert property (rdTk && regAddr == 12'h300 ##1 rdTk && regAddr == 12'h304
    |=> regRdData == $past(regRdData))
    else $error("set view differs");
  chk_clear_view: assert property (rdTk && regAddr == 12'h304 ##1 rdTk && regAddr == 12'h308
    |=> $stable(regRdData))
    else $error("clear view differs");
  chk_irq_masked: assert property (wrTk && regAddr == 12'h308 && regWrData[7:0] == 8'hFF
    |=> !irq)
    else $error("irq after disable");
  chk_pend_upper: assert property (rdTk && regAddr == 12'h30C |=> regRdData[31:8] == 0)
    else $error("pending upper bits set");
  chk_irq_pend: assert property (rdTk && regAddr == 12'h30C |=> irq == (regRdData[7:0] != 0))
    else $error("irq and pending disagree");
  // a pulse held by a frozen clock enable is the same pulse, not a new one
  chk_send_cause: assert property (chanOut != 0 |-> $past(!clkEn) ||
    $past(wrTk && regAddr < 12'h020 && regWrData[0]))
    else $error("channel pulse without trigger");
  chk_freeze_out: assert property (!clkEn |=> $stable(chanOut) && $stable(pubValid))
    else $error("outputs moved while frozen");
  cover property (pubValid != 0);
  cover property (irq);
  cover property (chanOut != 0);
endmodule
`default_nettype wire

/* tb/ipe_peer.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// peer event unit on the shared channels
// ****
module ipe_peer #(parameter int GAP = 40) (
  input  wire logic       sys_clk,
  input  wire logic [7:0] sendReq,
  input  wire logic [7:0] chanOut,
  output var  logic [7:0] chanLine,
  output var  int         rxCnt
);
  int         idle = 0;
  logic [7:0] lastOut = 8'h00;
  initial chanLine = 8'h00;
  initial rxCnt = 0;
  // lines held five cycles for the far filter; closer sends would merge
  always @(posedge sys_clk) begin
    idle <= idle + 1;
    if (sendReq != 8'h00 && idle >= GAP) begin
      chanLine <= sendReq;
      idle <= 0;
    end else if (idle == 4) begin
      chanLine <= 8'h00;
    end
    rxCnt <= rxCnt + $countones(chanOut & ~lastOut);
    lastOut <= chanOut;
  end
endmodule
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin \
  checkCount++; \
  if ((g) !== (e)) begin \
    errorCnt++; \
    $display("wrong value at %0t: %h not %h", $time, g, e); \
  end end
// ****
// bench
// ****
module tb;
  logic         sys_clk = 1'b0, nrst = 1'b0, clkEn = 1'b1, rdPend = 1'b0;
  logic         regWrEn = 1'b0, regRdEn = 1'b0, irq;
  logic [11:0]  regAddr = 12'h000;
  logic [31:0]  regWrData = 32'h0, regRdData, rdExp, d;
  logic [7:0]   chanIn, chanOut, pubValid, sendReq = 8'h00, enM, flagM = 8'h00, pubExp;
  logic [7:0]   pubSeen = 8'h00;
  logic [127:0] pubIndex;
  logic [31:0]  pubM [8], maskM [8], sendM [8], scrM [4];
  int           errorCnt = 0, checkCount = 0, cyc = 0, rxCnt, rxExp = 0;
  ipe_event_regs ipe_event_regs_i (.sys_clk(sys_clk), .nrst(nrst), .clkEn(clkEn),
    .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regRdData(regRdData), .chanIn(chanIn), .chanOut(chanOut), .pubValid(pubValid),
    .pubIndex(pubIndex), .irq(irq));
  ipe_peer #(.GAP(20)) ipe_peer_i (.sys_clk(sys_clk), .sendReq(sendReq), .chanOut(chanOut),
    .chanLine(chanIn), .rxCnt(rxCnt));
  initial forever #2.5 sys_clk = ~sys_clk;
  // publish pulses are short, so collect them
  always @(posedge sys_clk) pubSeen <= pubSeen | pubValid;
  // hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errorCnt++;
      testDone();
    end
  end
  // one bus cycle; a read is checked in the following call
  task automatic op(input logic w, r, input logic [11:0] a, input logic [31:0] wd, e);
    @(posedge sys_clk);
    regWrEn <= w;
    regRdEn <= r;
    regAddr <= a;
    regWrData <= wd;
    #1;
    if (rdPend) `CHK(regRdData, rdExp)
    rdPend = r;
    rdExp = e;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v); op(1, 0, a, v, 0); endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e); op(0, 1, a, 0, e); endtask
  task automatic idle(); op(0, 0, 12'h000, 0, 0); endtask
  task automatic testDone();
    $display("errors %0d checks %0d", errorCnt, checkCount);
    if (errorCnt == 0 && checkCount > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h85A8C58C));
    repeat (16) @(posedge sys_clk);
    nrst <= 1'b1;
    // reset values, then random configuration
    for (int n = 0; n < 8; n++) begin
      rd(12'(12'h180 + 4 * n), 0);
      rd(12'(12'h590 + 4 * n), 0);
      rd(12'(12'h100 + 4 * n), 0);
      pubM[n] = $urandom;
      maskM[n] = $urandom;
      sendM[n] = $urandom;
      scrM[n % 4] = $urandom;
    end
    rd(12'h30C, 0);
    rd(12'hFFC, 0);
    for (int n = 0; n < 8; n++) begin
      wr(12'(12'h180 + 4 * n), pubM[n]);
      wr(12'(12'h590 + 4 * n), maskM[n]);
      wr(12'(12'h510 + 4 * n), sendM[n]);
      wr(12'(12'h610 + 4 * (n % 4)), scrM[n % 4]);
    end
    for (int n = 0; n < 8; n++) begin
      rd(12'(12'h180 + 4 * n), pubM[n] & 32'h8000FFFF);
      rd(12'(12'h590 + 4 * n), maskM[n] & 32'h000000FF);
      rd(12'(12'h510 + 4 * n), sendM[n] & 32'h000000FF);
      rd(12'(12'h610 + 4 * (n % 4)), scrM[n % 4]);
    end
    // direct, set and clear views of the enables
    enM = 8'h00;
    for (int k = 0; k < 6; k++) begin
      d = $urandom;
      enM = (k % 3 == 0) ? d[7:0] : (k % 3 == 1) ? (enM | d[7:0]) : (enM & ~d[7:0]);
      wr(12'(12'h300 + 4 * (k % 3)), d);
      rd(12'h300, {24'h0, enM});
      rd(12'h304, {24'h0, enM});
      rd(12'h308, {24'h0, enM});
    end
    // send triggers, one frozen pulse and one ignored write
    for (int n = 0; n < 8; n++) begin
      wr(12'(4 * n), 32'h1);
      idle();
      `CHK(chanOut, sendM[n][7:0])
      rxExp += $countones(sendM[n][7:0]);
      clkEn <= (n != 7);
      repeat (2) idle();
      clkEn <= 1'b1;
    end
    wr(12'h000, 32'h2);
    idle();
    `CHK(chanOut, 8'h00)
    // peer events on every channel
    wr(12'h304, 32'hFF);
    enM = 8'hFF;
    for (int c = 0; c < 8; c++) begin
      pubExp = 8'h00;
      for (int n = 0; n < 8; n++) begin
        flagM[n] = flagM[n] | maskM[n][c];
        pubExp[n] = maskM[n][c] & pubM[n][31];
      end
      pubSeen = 8'h00;
      sendReq <= 8'(1 << c);
      idle();
      sendReq <= 8'h00;
      repeat (24) idle();
      `CHK(pubSeen, pubExp)
      `CHK(irq, |flagM)
      rd(12'h30C, {24'h0, flagM});
    end
    // mask, unmask, then clear each flag
    wr(12'h308, 32'hFF);
    idle();
    `CHK(irq, 1'b0)
    rd(12'h30C, 0);
    wr(12'h304, 32'hFF);
    idle();
    `CHK(irq, |flagM)
    for (int n = 0; n < 8; n++) begin
      `CHK(pubIndex[16 * n +: 16], pubM[n][15:0])
      rd(12'(12'h100 + 4 * n), {31'h0, flagM[n]});
      wr(12'(12'h100 + 4 * n), 0);
    end
    idle();
    `CHK(irq, 1'b0)
    `CHK(rxCnt, rxExp)
    testDone();
  end
endmodule
bind ipe_event_regs ipe_event_regs_asserts #(.NEV(NEV), .NCH(NCH)) chk_i (.*);
`default_nettype wire
